// file: core/lcdcfg_top.sv
// display drive configuration: APB registers, clock source, prescaler and frame timing
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module lcdcfg_top #(
    parameter bit WIDE_VARIANT = 1'b1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous clock sources
    input wire logic timer_osc_clk,
    input wire logic ext_clk,
    input wire logic external_clock_input_sel,
    // display drive controls toward the pads
    output logic [3:0] common_terminals_en,
    output logic [39:0] segment_terminals_en,
    output logic half_bias_drive,
    output logic static_drive,
    output logic [1:0] duty_active,
    // frame timing
    output logic prescaled_display_clock,
    output logic frame_start,
    output logic [2:0] frame_step
);
    // software registers
    logic [7:0] drive_cfg_reg;
    logic [7:0] frame_rate_reg;
    // frame-aligned copies used by the timing logic
    logic [7:0] cfg_act_reg;
    logic [7:0] frr_act_reg;
    logic [5:0] seg_cnt_reg;
    logic [3:0] com_en_reg;
    logic half_reg;
    logic static_reg;
    logic [31:0] rdata_reg;
    logic err_reg;
    logic [2:0] step_reg;
    logic frame_reg;

    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic hit_cfg;
    logic hit_frr;
    logic timer_rise;
    logic ext_rise;
    logic async_rise;
    logic src_tick;
    logic ps_tick;
    logic [3:0] k_len;
    logic [1:0] live_duty;

    // ---- APB slave ----
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign hit_cfg = (paddr == lcdcfg_pkg::ADDR_DRIVE_CONFIG);
    assign hit_frr = (paddr == lcdcfg_pkg::ADDR_FRAME_RATE);
    // always ready in the access phase, data was fetched during setup
    assign pready = access_ph;
    assign wr_en = access_ph && pwrite && pstrb[0];
    assign prdata = rdata_reg;
    assign pslverr = err_reg && access_ph;

    // read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (setup_ph) begin
            err_reg <= !(hit_cfg || hit_frr);
            if (pwrite) begin
                rdata_reg <= 32'h0000_0000;
            end else if (hit_cfg) begin
                rdata_reg <= {24'h00_0000, drive_cfg_reg};
            end else if (hit_frr) begin
                rdata_reg <= {24'h00_0000, frame_rate_reg};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    // register writes take effect at the completing access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_cfg_reg <= lcdcfg_pkg::DRIVE_CONFIG_RST;
            frame_rate_reg <= lcdcfg_pkg::FRAME_RATE_RST;
        end else if (wr_en) begin
            if (hit_cfg) begin
                // the narrow part has no storage behind the mask msb
                drive_cfg_reg <= WIDE_VARIANT ? pwdata[7:0]
                    : (pwdata[7:0] & lcdcfg_pkg::NARROW_CFG_MASK);
            end
            if (hit_frr) begin
                frame_rate_reg <= pwdata[7:0] & lcdcfg_pkg::FRAME_RATE_RW_MASK;
            end
        end
    end

    // ---- display clock source ----
    lcdcfg_sync u_sync_timer (
        .clk(pclk),
        .rst_n(presetn),
        .pin(timer_osc_clk),
        .rise(timer_rise)
    );

    lcdcfg_sync u_sync_ext (
        .clk(pclk),
        .rst_n(presetn),
        .pin(ext_clk),
        .rise(ext_rise)
    );

    // async edges become enables, so the whole block stays on pclk
    assign async_rise = external_clock_input_sel ? ext_rise : timer_rise;
    // source select is live so software can leave a stopped oscillator
    assign src_tick = drive_cfg_reg[lcdcfg_pkg::CLK_SRC_BIT] ? async_rise : 1'b1;

    lcdcfg_prescaler u_presc (
        .clk(pclk),
        .rst_n(presetn),
        .src_tick(src_tick),
        .tap_sel(frr_act_reg[lcdcfg_pkg::TAP_LSB +: 3]),
        .div_sel(frr_act_reg[lcdcfg_pkg::DIV_LSB +: 3]),
        .ps_tick(ps_tick)
    );

    // ---- frame timing ----
    // third duty frames are six ticks long, all others eight
    assign k_len = (cfg_act_reg[lcdcfg_pkg::DUTY_LSB +: 2] == 2'(lcdcfg_pkg::DUTY_THIRD))
        ? lcdcfg_pkg::K_THIRD_DUTY : lcdcfg_pkg::K_OTHER_DUTY;

    // step counter over one frame, one-cycle frame pulse on wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_reg <= 3'h0;
            frame_reg <= 1'b0;
        end else begin
            frame_reg <= ps_tick && ({1'b0, step_reg} == k_len - 4'h1);
            if (ps_tick) begin
                step_reg <= ({1'b0, step_reg} == k_len - 4'h1) ? 3'h0 : step_reg + 3'h1;
            end
        end
    end

    assign live_duty = drive_cfg_reg[lcdcfg_pkg::DUTY_LSB +: 2];

    // settings move to the timing logic only at a frame boundary, so
    // a frame never mixes old and new prescaler or duty values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_act_reg <= lcdcfg_pkg::DRIVE_CONFIG_RST;
            frr_act_reg <= lcdcfg_pkg::FRAME_RATE_RST;
        end else if (frame_reg) begin
            cfg_act_reg <= drive_cfg_reg;
            frr_act_reg <= frame_rate_reg;
        end
    end

    // pad controls follow the same boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            com_en_reg <= lcdcfg_pkg::lcdcfg_com_mask(2'h0);
            seg_cnt_reg <= lcdcfg_pkg::lcdcfg_seg_count(4'h0);
            half_reg <= 1'b0;
            static_reg <= 1'b1;
        end else if (frame_reg) begin
            com_en_reg <= lcdcfg_pkg::lcdcfg_com_mask(live_duty);
            seg_cnt_reg <= lcdcfg_pkg::lcdcfg_seg_count(
                drive_cfg_reg[lcdcfg_pkg::PORT_MASK_LSB +: 4]);
            // static duty drives static whatever the bias bit says
            static_reg <= (live_duty == 2'(lcdcfg_pkg::DUTY_STATIC));
            half_reg <= drive_cfg_reg[lcdcfg_pkg::HALF_BIAS_BIT]
                && (live_duty != 2'(lcdcfg_pkg::DUTY_STATIC));
        end
    end

    // segments below the selected count belong to the display
    for (genvar i = 0; i < 40; i++) begin : g_seg
        assign segment_terminals_en[i] = (6'(i) < seg_cnt_reg);
    end

    assign common_terminals_en = com_en_reg;
    assign half_bias_drive = half_reg;
    assign static_drive = static_reg;
    assign duty_active = cfg_act_reg[lcdcfg_pkg::DUTY_LSB +: 2];
    assign prescaled_display_clock = ps_tick;
    assign frame_start = frame_reg;
    assign frame_step = step_reg;

    // ---- checks ----
    AST_SYS_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
        !drive_cfg_reg[lcdcfg_pkg::CLK_SRC_BIT] |-> src_tick)
        else $error("system clock source must tick every cycle");

    AST_ASYNC_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
        drive_cfg_reg[lcdcfg_pkg::CLK_SRC_BIT] && src_tick |->
        (external_clock_input_sel ? ext_rise : timer_rise))
        else $error("async tick from wrong source");

    AST_COMMONS: assert property (@(posedge pclk) disable iff (!presetn)
        frame_reg |=> common_terminals_en ==
        lcdcfg_pkg::lcdcfg_com_mask($past(live_duty)))
        else $error("common enables do not match duty");

    AST_QUARTER_ALL: assert property (@(posedge pclk) disable iff (!presetn)
        duty_active == 2'h3 |-> common_terminals_en == 4'hF)
        else $error("quarter duty must drive four commons");

    AST_HALF_BIAS: assert property (@(posedge pclk) disable iff (!presetn)
        frame_reg |=> half_bias_drive ==
        ($past(drive_cfg_reg[6]) && $past(live_duty) != 2'h0))
        else $error("bias select not applied");

    AST_STATIC_NO_BIAS: assert property (@(posedge pclk) disable iff (!presetn)
        static_drive |-> !half_bias_drive && duty_active == 2'h0)
        else $error("static duty with half bias");

    AST_SEG_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        seg_cnt_reg >= 6'h0D && seg_cnt_reg <= 6'h28 |->
        segment_terminals_en[seg_cnt_reg - 6'h01] &&
        (seg_cnt_reg == 6'h28 || !segment_terminals_en[seg_cnt_reg]))
        else $error("segment enables do not end at count");

    AST_SEG_MAX24: assert property (@(posedge pclk) disable iff (!presetn)
        frame_reg && drive_cfg_reg[3:0] == 4'h6 |=> seg_cnt_reg == 6'h18)
        else $error("mask code six must give 24 segments");

    AST_NARROW_MSB: assert property (@(posedge pclk) disable iff (!presetn)
        !WIDE_VARIANT |-> !drive_cfg_reg[lcdcfg_pkg::MASK_MSB_BIT])
        else $error("mask msb set on narrow variant");

    AST_FRR_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit_frr |-> prdata[7] == 1'b0 && prdata[3] == 1'b0)
        else $error("reserved frame rate bits read nonzero");

    AST_CFG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !frame_reg |=> $stable(cfg_act_reg) && $stable(frr_act_reg))
        else $error("active config changed mid frame");

    AST_FRAME_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        frame_reg |-> step_reg == 3'h0 && $past(step_reg) == 3'(k_len - 4'h1))
        else $error("frame did not last K ticks");

    AST_WRITE_SEEN: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_frr |=> frame_rate_reg[6:4] == $past(pwdata[6:4]))
        else $error("tap select write lost");

endmodule : lcdcfg_top

// file: shared/lcdcfg_pkg.sv
// constants, types and decode functions for the display drive configuration block
// Overview of operation
// - source select zero uses system clock
// - async source: timer oscillator or external clock
// - bias bit picks third or half bias
// - duty code sets duty and active commons
// - unused commons go back to ports
// - static duty ignores bias bit
// - port mask code sets segment terminal count
// - segments above range stay port pins
// - narrow variant: mask msb reads zero
// - tap select gives ratio 16 to 4096
// - tap output divided again by divider
// - frame rate bits 7,3 read zero
// - divide factor is code plus one
// - frame is K times N times D
package lcdcfg_pkg;

    // register indices as printed, byte address is four times the index
    localparam logic [9:0] IDX_DRIVE_CONFIG = 10'h0E5;
    localparam logic [9:0] IDX_FRAME_RATE = 10'h0E6;
    localparam logic [11:0] ADDR_DRIVE_CONFIG = {IDX_DRIVE_CONFIG, 2'h0};
    localparam logic [11:0] ADDR_FRAME_RATE = {IDX_FRAME_RATE, 2'h0};

    // reset values
    localparam logic [7:0] DRIVE_CONFIG_RST = 8'h00;
    localparam logic [7:0] FRAME_RATE_RST = 8'h00;

    // display_drive_config fields
    localparam int CLK_SRC_BIT = 7;
    localparam int HALF_BIAS_BIT = 6;
    localparam int DUTY_LSB = 4;
    localparam int PORT_MASK_LSB = 0;
    localparam int MASK_MSB_BIT = 3;
    localparam logic [7:0] NARROW_CFG_MASK = 8'hF7;

    // display_frame_rate fields, bits 7 and 3 are reserved
    localparam int TAP_LSB = 4;
    localparam int DIV_LSB = 0;
    localparam logic [7:0] FRAME_RATE_RW_MASK = 8'h77;

    // frame length in prescaled ticks
    localparam logic [3:0] K_THIRD_DUTY = 4'h6;
    localparam logic [3:0] K_OTHER_DUTY = 4'h8;

    // prescaler counter width covers the largest tap
    localparam int PRESC_W = 12;

    typedef enum logic [1:0] {
        DUTY_STATIC,
        DUTY_HALF,
        DUTY_THIRD,
        DUTY_QUARTER
    } lcdcfg_duty_t;

    // log2 of the prescaler ratio for a tap code
    function automatic logic [3:0] lcdcfg_tap_log2(input logic [2:0] tap);
        lcdcfg_tap_log2 = (tap == 3'h0) ? 4'h4 : 4'({1'b0, tap} + 4'h5);
    endfunction : lcdcfg_tap_log2

    // commons driven for a duty code
    function automatic logic [3:0] lcdcfg_com_mask(input logic [1:0] duty);
        lcdcfg_com_mask = 4'(5'h0F >> (2'h3 - duty));
    endfunction : lcdcfg_com_mask

    // number of segment terminals driven for a port mask code
    function automatic logic [5:0] lcdcfg_seg_count(input logic [3:0] pm);
        if (pm <= 4'h5) begin
            lcdcfg_seg_count = 6'(6'h0D + {pm, 1'b0});
        end else if (pm == 4'h6) begin
            lcdcfg_seg_count = 6'h18;
        end else if (pm == 4'h7) begin
            lcdcfg_seg_count = 6'h19;
        end else if (pm == 4'hF) begin
            lcdcfg_seg_count = 6'h28;
        end else begin
            lcdcfg_seg_count = 6'(6'h1B + {pm[2:0], 1'b0});
        end
    endfunction : lcdcfg_seg_count

endpackage : lcdcfg_pkg

// file: core/lcdcfg_sync.sv
// two-flop synchroniser for a clock pin with rising edge pulse
`timescale 1ns/1ps
module lcdcfg_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin and result
    input wire logic pin,
    output logic rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // first flop feeds only the second, edge taken behind them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign rise = sync_reg & ~last_reg;

endmodule : lcdcfg_sync

// file: core/lcdcfg_prescaler.sv
// prescaler tap and clock divider producing the prescaled display tick
`timescale 1ns/1ps
module lcdcfg_prescaler (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // source tick and settings
    input wire logic src_tick,
    input wire logic [2:0] tap_sel,
    input wire logic [2:0] div_sel,
    // prescaled tick
    output logic ps_tick
);
    logic [lcdcfg_pkg::PRESC_W-1:0] cnt_reg;
    logic [lcdcfg_pkg::PRESC_W-1:0] tap_mask;
    logic [2:0] div_reg;
    logic tap_hit;

    // tap fires when the low log2(N) bits are all ones
    assign tap_mask = lcdcfg_pkg::PRESC_W'((13'h1 << lcdcfg_pkg::lcdcfg_tap_log2(tap_sel)) - 13'h1);
    assign tap_hit = src_tick && ((cnt_reg & tap_mask) == tap_mask);

    // free-running prescaler, advanced only by source ticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (src_tick) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // divide tap output by code plus one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 3'h0;
            ps_tick <= 1'b0;
        end else begin
            ps_tick <= tap_hit && (div_reg >= div_sel);
            if (tap_hit) begin
                div_reg <= (div_reg >= div_sel) ? 3'h0 : div_reg + 3'h1;
            end
        end
    end

    // helper: source ticks between two outputs with steady settings
    logic [15:0] since_reg;
    logic steady_reg;
    logic [15:0] expect_n;
    assign expect_n = 16'((17'h1 << lcdcfg_pkg::lcdcfg_tap_log2(tap_sel)) * ({1'b0, div_sel} + 4'h1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_reg <= 16'h0000;
            steady_reg <= 1'b0;
        end else begin
            if (ps_tick) begin
                since_reg <= {15'h0000, src_tick};
            end else if (src_tick) begin
                since_reg <= since_reg + 16'h0001;
            end
            if ($changed(tap_sel) || $changed(div_sel)) begin
                steady_reg <= 1'b0;
            end else if (ps_tick) begin
                steady_reg <= 1'b1;
            end
        end
    end

    AST_TICK_RATIO: assert property (@(posedge clk) disable iff (!rst_n)
        ps_tick && steady_reg && $stable(tap_sel) && $stable(div_sel) |-> since_reg == expect_n)
        else $error("prescaled tick spacing differs from N times D");

endmodule : lcdcfg_prescaler

// file: sim/lcdcfg_clk_model.sv
// model of the two asynchronous clock sources seen at the display clock pins
`timescale 1ns/1ps
module lcdcfg_clk_model #(
    parameter real OSC_HALF = 20.0,
    parameter real EXT_HALF = 30.0
) (
    // run controls from the bench
    input wire logic osc_run,
    input wire logic ext_run,
    // clock pins toward the block
    output logic timer_osc_clk,
    output logic ext_clk
);
    // timer oscillator, parked low while stopped so no stray edge leaks
    initial begin
        timer_osc_clk = 1'b0;
        #1.3;
        forever begin
            #OSC_HALF;
            timer_osc_clk = osc_run ? ~timer_osc_clk : 1'b0;
        end
    end

    // external clock, phase unrelated to pclk and to the oscillator
    initial begin
        ext_clk = 1'b0;
        #2.7;
        forever begin
            #EXT_HALF;
            ext_clk = ext_run ? ~ext_clk : 1'b0;
        end
    end
endmodule : lcdcfg_clk_model

// file: sim/lcd_drive_config_prescaler_tb.sv
// self-checking bench for the display drive configuration block
`timescale 1ns/1ps
module lcd_drive_config_prescaler_tb;
    localparam logic [11:0] DRV = lcdcfg_pkg::ADDR_DRIVE_CONFIG;
    localparam logic [11:0] FRR = lcdcfg_pkg::ADDR_FRAME_RATE;
    logic pclk, presetn, psel, penable, pwrite, ext_sel, osc_run, ext_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, nar_rd;
    logic [3:0] pstrb, common_terminals_en;
    logic pready, pslverr, err, half_bias_drive, static_drive;
    logic timer_osc_clk, ext_clk, prescaled_display_clock, frame_start;
    logic [39:0] segment_terminals_en;
    logic [1:0] duty_active;
    logic [2:0] frame_step;
    int err_count, n_compared, cyc, n;
    int segs[16] = '{13, 15, 17, 19, 21, 23, 24, 25, 27, 29, 31, 33, 35, 37, 39, 40};
    int taps[8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
    logic [3:0] coms[4] = '{4'h1, 4'h3, 4'h7, 4'hF};

    lcdcfg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_osc_clk(timer_osc_clk),
        .ext_clk(ext_clk), .external_clock_input_sel(ext_sel),
        .common_terminals_en(common_terminals_en), .segment_terminals_en(segment_terminals_en),
        .half_bias_drive(half_bias_drive), .static_drive(static_drive),
        .duty_active(duty_active), .prescaled_display_clock(prescaled_display_clock),
        .frame_start(frame_start), .frame_step(frame_step));

    // small-package variant on the same bus, only its read data is watched
    lcdcfg_top #(.WIDE_VARIANT(1'b0)) narrow_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(nar_rd), .pready(), .pslverr(),
        .timer_osc_clk(timer_osc_clk), .ext_clk(ext_clk),
        .external_clock_input_sel(ext_sel), .common_terminals_en(),
        .segment_terminals_en(), .half_bias_drive(), .static_drive(), .duty_active(),
        .prescaled_display_clock(), .frame_start(), .frame_step());

    lcdcfg_clk_model part_u (.osc_run(osc_run), .ext_run(ext_run),
        .timer_osc_clk(timer_osc_clk), .ext_clk(ext_clk));

    // 200 MHz bus clock
    always #2.5 pclk = ~pclk;

    task automatic wrap_up();
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // hang guard, well above the longest expected run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; waits for pready, then releases and lets an edge pass
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
        input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // cycles until the next pulse of frame_start (sel 1) or the prescaled clock (sel 0)
    task automatic wait_pulse(input logic sel, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while ((sel ? frame_start : prescaled_display_clock) !== 1'b1 && c < 40000);
    endtask : wait_pulse

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, ext_sel, osc_run, ext_run} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // pad state after reset: static duty, common 0 and 13 segments
        chk(common_terminals_en, 4'h1);
        chk(segment_terminals_en, 40'h00_0000_1FFF);
        chk({static_drive, half_bias_drive}, 2'h2);
        apb(1'b0, DRV, 8'h00, 4'hF);
        chk(rd, 32'h0);
        apb(1'b1, FRR, 8'hFF, 4'hF);
        apb(1'b0, FRR, 8'h00, 4'hF);
        chk(rd, 32'h77);
        // lane 0 strobe low leaves the register alone
        apb(1'b1, FRR, 8'h00, 4'hE);
        apb(1'b0, FRR, 8'h00, 4'hF);
        chk(rd, 32'h77);
        apb(1'b1, 12'h3A0, 8'h5A, 4'hF);
        chk(err, 1'b1);
        apb(1'b0, 12'h3A0, 8'h00, 4'hF);
        chk({err, rd}, {1'b1, 32'h0});
        apb(1'b1, FRR, 8'h00, 4'hF);
        // every duty code and port mask code, bias toggled along the way
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, DRV, {1'b0, i[2], i[1:0], i[3:0]}, 4'hF);
            apb(1'b0, DRV, 8'h00, 4'hF);
            chk(rd, {24'h0, 1'b0, i[2], i[1:0], i[3:0]});
            chk(nar_rd, {24'h0, 1'b0, i[2], i[1:0], 1'b0, i[2:0]});
            wait_pulse(1'b1, n);
            chk(frame_step, 3'h0);
            wait_pulse(1'b1, n);
            chk(n, (i[1:0] == 2'h2 ? 6 : 8) * 16);
            chk(common_terminals_en, coms[i[1:0]]);
            chk(duty_active, i[1:0]);
            chk(static_drive, i[1:0] == 2'h0);
            chk(half_bias_drive, i[2] && i[1:0] != 2'h0);
            chk(segment_terminals_en, 40'((64'h1 << segs[i]) - 64'h1));
        end
        // prescaler tap codes 0 to 3, then divide codes on the shortest tap
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, FRR, {1'b0, 3'(i < 4 ? i : 0), 1'b0, 3'(i < 4 ? 0 : i - 3)}, 4'hF);
            wait_pulse(1'b1, n);
            wait_pulse(1'b0, n);
            wait_pulse(1'b0, n);
            chk(n, taps[i < 4 ? i : 0] * (i < 4 ? 1 : i - 2));
        end
        // asynchronous source: oscillator at 8 pclk, then external at 12 pclk
        apb(1'b1, FRR, 8'h00, 4'hF);
        wait_pulse(1'b1, n);
        osc_run <= 1'b1;
        apb(1'b1, DRV, 8'h80, 4'hF);
        wait_pulse(1'b0, n);
        wait_pulse(1'b0, n);
        chk(n, 16 * 8);
        ext_run <= 1'b1;
        ext_sel <= 1'b1;
        wait_pulse(1'b0, n);
        wait_pulse(1'b0, n);
        chk(n, 16 * 12);
        // back on the system clock the tap runs every cycle again
        apb(1'b1, DRV, 8'h00, 4'hF);
        wait_pulse(1'b0, n);
        wait_pulse(1'b0, n);
        chk(n, 16);
        wrap_up();
    end
endmodule : lcd_drive_config_prescaler_tb
